/* shared/scan_port_defines.vh */
// Constants shared by the scan-port addressing block
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH

// Bit-pair symbols, first bit in the high position
`define SYM_IDLE        2'b11
`define SYM_SELECT      2'b00
`define SYM_ONE         2'b01
`define SYM_ZERO        2'b10

// Message field sizes
`define ADDR_BITS       4'ha
`define ADDR_LONG       4'hb
`define CMD_GROUP_LAST  3'h5

// Acknowledge symbol sequence: I S A0..A9 S S C0..C5 S I
`define ACK_ADDR_FIRST  5'h02
`define ACK_ADDR_LAST   5'h0b
`define ACK_CMD_FIRST   5'h0e
`define ACK_CMD_LAST    5'h13
`define ACK_IDLE_LAST   5'h15
`define ACK_SYMS        5'h16

// TAP monitor state bit positions (one-hot)
`define TAP_TLR   0
`define TAP_RTI   1
`define TAP_SDR   2
`define TAP_CDR   3
`define TAP_SHD   4
`define TAP_E1D   5
`define TAP_PDR   6
`define TAP_E2D   7
`define TAP_UDR   8
`define TAP_SIR   9
`define TAP_CIR   10
`define TAP_SHI   11
`define TAP_E1I   12
`define TAP_PIR   13
`define TAP_E2I   14
`define TAP_UIR   15

// Protocol results
`define RES_NONE      3'h0
`define RES_NO_MATCH  3'h1
`define RES_MATCH     3'h2
`define RES_SOFT      3'h3
`define RES_HARD      3'h4
`define RES_TSYNC     3'h5
`define RES_RESET     3'h6

// Connect status codes
`define CONN_OFF      2'h0
`define CONN_ON       2'h1
`define CONN_RESET    2'h2
`define CONN_BYPASS   2'h3

// Register map (byte addresses) and fields
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_RXDATA    8'h08
`define CTRL_RESET    1'h0
`define ST_CONN_LSB   4
`define ST_ACK_BIT    8
`define ST_RX_BIT     9
`define ST_TAP_LSB    16
`define RX_POS_LSB    16
`define RX_CFG_LSB    20
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

/* sim/scan_bus_master.sv */
// Behavioural test-bus master on the primary test port
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_bus_master (
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic [43:0] rx;
  int          nrx, nb;
  int          flip_at = -1;
  // Clock stops between frames; idle data stays high
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic bit1(input logic b);
    tdi = b;
    nb++;
    if (nb == flip_at)
      tms = ~tms;
    #15 tck = 1'b1; // Off the aclk edge
    if (tdo_oe === 1'b1)
    begin
      rx = {rx[42:0], tdo};
      nrx++;
    end
    #16 tck = 1'b0;
    #1;
  endtask
  task automatic sym(input logic [1:0] s);
    bit1(s[1]);
    bit1(s[0]);
  endtask
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      bit1(v[i]);
  endtask
  task automatic tap(input logic [7:0] s, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      tms = s[i];
      bit1(1'b1);
    end
  endtask
  // Trailing idle clocks the acknowledge out
  task automatic msg(input logic [9:0] a, input int na, input logic [5:0] c, input int nc);
    rx = 44'h0;
    nrx = 0;
    nb = 0;
    repeat (2) sym(`SYM_IDLE);
    sym(`SYM_SELECT);
    for (int i = 0; i < na; i++)
      sym(a[i % 10] ? `SYM_ONE : `SYM_ZERO);
    repeat (2) sym(`SYM_SELECT);
    for (int i = 0; i < nc; i++)
      sym(c[i % 6] ? `SYM_ONE : `SYM_ZERO);
    sym(`SYM_SELECT);
    sym(`SYM_IDLE);
    flip_at = -1;
    repeat (3) bits(16'hffff, 16);
  endtask
endmodule
`default_nettype wire

/* sim/scan_port_shadow_protocol_assertions.sv */
// Port-level checks for the addressing block
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_port_chk (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Watched outputs
  input wire logic       primary_serial_out,
  input wire logic       primary_serial_out_oe,
  input wire logic [1:0] connect_status_outputs,
  input wire logic [2:0] protocol_result
);
  logic [9:0] oe_cnt_q;
  wire  [2:0] r = protocol_result;
  wire  [1:0] c = connect_status_outputs;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Enable length tells a full acknowledge from an aborted one
  always @(posedge aclk)
    oe_cnt_q <= (aresetn && primary_serial_out_oe) ? oe_cnt_q + 10'h1 : 10'h0;
  sequence s_ack_full;
    $fell(primary_serial_out_oe) ##0 (oe_cnt_q >= 10'h15f);
  endsequence
  sequence s_new(logic [2:0] v);
    $changed(r) ##0 (r == v);
  endsequence
  a_idle_high: assert property (!primary_serial_out_oe |-> primary_serial_out)
    else $error("released output not high");
  a_ack_framing: assert property ($rose(primary_serial_out_oe) |-> ##4 primary_serial_out ##8 primary_serial_out ##8 !primary_serial_out)
    else $error("bad acknowledge opening");
  a_ack_length: assert property ($fell(primary_serial_out_oe) |-> oe_cnt_q <= 10'h161)
    else $error("acknowledge too long");
  a_ack_on_match: assert property ($rose(primary_serial_out_oe) |-> r == `RES_MATCH)
    else $error("acknowledge without match");
  a_on_after_ack: assert property (s_ack_full |-> ##[1:8] (c == `CONN_ON || c == `CONN_BYPASS))
    else $error("not on after acknowledge");
  a_match_order: assert property (s_new(`RES_MATCH) |-> $past(r) == `RES_NO_MATCH)
    else $error("match not preceded by no-match");
  a_nomatch_off: assert property (s_new(`RES_NO_MATCH) |-> ##[0:2] c != `CONN_ON)
    else $error("no-match left status on");
  a_hard_off: assert property (s_new(`RES_HARD) |-> ##[0:2] c != `CONN_ON)
    else $error("hard error left status on");
  a_soft_quiet: assert property (s_new(`RES_SOFT) |-> $stable(c) [*3])
    else $error("soft error changed status");
endmodule
bind scan_port_shadow_protocol scan_port_chk chk (
  .aclk(aclk), .aresetn(aresetn), .primary_serial_out(primary_serial_out),
  .primary_serial_out_oe(primary_serial_out_oe), .connect_status_outputs(connect_status_outputs),
  .protocol_result(protocol_result));
`default_nettype wire

/* sim/test_scan_port_shadow_protocol.sv */
// Self-checking bench for the addressing block
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"
module test_scan_port_shadow_protocol;
  logic        aclk;
  logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        trst_n = 1'b1;
  wire         awready, wready, bvalid, arready, rvalid, tck, tms, tdi, tdo, tdo_oe;
  wire  [1:0]  bresp, rresp, conn;
  wire  [2:0]  cfg, res;
  wire  [31:0] rdata;
  int          failures = 0;
  int          total_checks = 0;
  scan_port_shadow_protocol dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .primary_test_clock(tck), .primary_mode_select(tms), .primary_serial_in(tdi),
    .primary_test_reset_n(trst_n), .primary_serial_out(tdo), .primary_serial_out_oe(tdo_oe),
    .group_address_inputs(10'h2a5), .chain_position_inputs(3'h5), .bypass_config_inputs(3'h3),
    .connect_status_outputs(conn), .secondary_config(cfg), .protocol_result(res));
  scan_bus_master m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    if (n >= 200)
    begin
      failures++;
      $display("wrong value at %0t: no bus answer", $time);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int   n = 0;
    logic aw = 1'b1, w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw || w) && n < 200)
    begin
      @(posedge aclk);
      n++;
      aw = aw && awready !== 1'b1;
      w = w && wready !== 1'b1;
      awvalid <= aw;
      wvalid <= w;
    end
    while (bvalid !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    bready <= 1'b0;
    wt(n);
    cmp(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (arready !== 1'b1 && n < 200);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    rready <= 1'b0;
    wt(n);
    cmp(rdata & mk, e);
    cmp(rresp, er);
  endtask
  task automatic chk(input logic [2:0] er, input logic [1:0] ec);
    repeat (8) @(posedge aclk);
    cmp(res, er);
    cmp(conn, ec);
  endtask
  task automatic tr(input logic [9:0] a, input int na, input logic [5:0] c, input int nc,
                    input logic [2:0] er, input logic [1:0] ec);
    m.msg(a, na, c, nc);
    chk(er, ec);
  endtask
  function automatic logic [63:0] ackv(input logic [9:0] a, input logic [5:0] c);
    logic [63:0] v;
    v = 64'hc;
    for (int i = 0; i < 10; i++)
      v = {v[61:0], a[i] ? 2'h1 : 2'h2};
    v = {v[59:0], 4'h0};
    for (int i = 0; i < 6; i++)
      v = {v[61:0], c[i] ? 2'h1 : 2'h2};
    return {v[59:0], 4'h3};
  endfunction
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`REG_STATUS, 32'hffff_ffff, 32'h0001_0000, `RESP_OKAY);
    rd(`REG_CTRL, 32'h1, 32'h0, `RESP_OKAY);
    rd(8'h0c, 32'hffff_ffff, 32'h0, `RESP_DECERR);
    wr(8'h0c, 32'h1, `RESP_DECERR);
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    chk(`RES_NONE, `CONN_BYPASS);
    cmp(cfg, 3'h3);
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    $display("registers done");
    tr(10'h2a5, 10, 6'h35, 6, `RES_MATCH, `CONN_ON);
    cmp(m.nrx, 44);
    cmp(m.rx, ackv(10'h2a5, 6'h35));
    cmp(cfg, 3'h6);
    rd(`REG_RXDATA, 32'hffff_ffff, {9'h0, 3'h6, 1'h0, 3'h5, 6'h0, 10'h2a5}, `RESP_OKAY);
    tr(10'h2a5, 9, 6'h35, 6, `RES_HARD, `CONN_OFF);
    tr(10'h2a4, 10, 6'h35, 6, `RES_NO_MATCH, `CONN_OFF);
    cmp(m.nrx, 0);
    tr(10'h2a5, 10, 6'h34, 6, `RES_NO_MATCH, `CONN_OFF);
    tr(10'h2a5, 11, 6'h35, 6, `RES_HARD, `CONN_OFF);
    tr(10'h2a5, 10, 6'h35, 5, `RES_HARD, `CONN_OFF);
    tr(10'h000, 12, 6'h35, 6, `RES_RESET, `CONN_RESET);
    tr(10'h3ff, 12, 6'h35, 6, `RES_HARD, `CONN_OFF);
    $display("message outcomes done");
    tr(10'h2a5, 10, 6'h35, 6, `RES_MATCH, `CONN_ON);
    m.bits(16'h03cf, 10);
    chk(`RES_SOFT, `CONN_ON);
    m.tap(8'h04, 4);
    tr(10'h2a5, 10, 6'h35, 6, `RES_SOFT, `CONN_ON);
    cmp(m.nrx, 0);
    m.tap(8'h1f, 5);
    m.tap(8'h0a, 5);
    rd(`REG_STATUS, 32'hffff_0000, 32'h0040_0000, `RESP_OKAY);
    tr(10'h3ff, 12, 6'h35, 6, `RES_TSYNC, `CONN_OFF);
    tr(10'h2a5, 10, 6'h35, 6, `RES_MATCH, `CONN_ON);
    m.flip_at = 43;
    tr(10'h2a5, 10, 6'h35, 6, `RES_HARD, `CONN_OFF);
    m.tap(8'h1f, 5);
    tr(10'h2a5, 10, 6'h35, 6, `RES_MATCH, `CONN_ON);
    $display("tap state cases done");
    m.tap(8'h02, 3);
    rd(`REG_STATUS, 32'hffff_0000, 32'h0008_0000, `RESP_OKAY);
    trst_n <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(`REG_STATUS, 32'hffff_0000, 32'h0001_0000, `RESP_OKAY);
    trst_n <= 1'b1;
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/ack_transmitter.v */
// Bit-pair serializer for the acknowledge message
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"

module ack_transmitter (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Control
  input  wire        start,
  input  wire [15:0] value,
  input  wire        shift,
  input  wire        abort,
  // Serial side
  output reg         serial_q,
  output reg         oe_q,
  output reg         busy_q,
  output reg         done_q
);

  reg [4:0]  sidx_q;
  reg        half_q;
  reg [15:0] sr_q;
  wire       is_data;
  wire       is_idle;
  wire       bit_now;

  assign is_data = ((sidx_q >= `ACK_ADDR_FIRST) && (sidx_q <= `ACK_ADDR_LAST)) ||
                   ((sidx_q >= `ACK_CMD_FIRST) && (sidx_q <= `ACK_CMD_LAST));
  assign is_idle = (sidx_q == 5'h00) || (sidx_q == `ACK_IDLE_LAST);
  // One is low-high, zero high-low
  assign bit_now = is_data ? (half_q ? sr_q[0] : ~sr_q[0]) : is_idle;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sidx_q   <= 5'h00;
      half_q   <= 1'b0;
      sr_q     <= 16'h0000;
      serial_q <= 1'b1;
      oe_q     <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q   <= 1'b0;
        oe_q     <= 1'b0;
        serial_q <= 1'b1;
      end
      else if (start)
      begin
        sidx_q <= 5'h00;
        half_q <= 1'b0;
        sr_q   <= value;
        busy_q <= 1'b1;
      end
      // Falling-edge updates give the master a settled level
      else if (busy_q && shift)
      begin
        if (sidx_q == `ACK_SYMS)
        begin
          busy_q   <= 1'b0;
          oe_q     <= 1'b0;
          serial_q <= 1'b1;
          done_q   <= 1'b1;
        end
        else
        begin
          serial_q <= bit_now;
          oe_q     <= 1'b1;
          half_q   <= ~half_q;
          if (half_q)
          begin
            sidx_q <= sidx_q + 5'h01;
            if (is_data)
              sr_q <= {1'b0, sr_q[15:1]};
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/scan_port_shadow_protocol.v */
// Addressing-message receiver, matcher and acknowledge control on the primary test port
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"

module scan_port_shadow_protocol (
  // System clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Primary test port pins
  input  wire        primary_test_clock,
  input  wire        primary_mode_select,
  input  wire        primary_serial_in,
  input  wire        primary_test_reset_n,
  output reg         primary_serial_out,
  output reg         primary_serial_out_oe,
  // Straps and bypass
  input  wire [9:0]  group_address_inputs,
  input  wire [2:0]  chain_position_inputs,
  input  wire [2:0]  bypass_config_inputs,
  // Secondary connection control
  output reg  [1:0]  connect_status_outputs,
  output reg  [2:0]  secondary_config,
  output reg  [2:0]  protocol_result
);

  localparam [5:0] M_WAIT = 6'h01;
  localparam [5:0] M_IDLE = 6'h02;
  localparam [5:0] M_ADDR = 6'h04;
  localparam [5:0] M_MID  = 6'h08;
  localparam [5:0] M_CMD  = 6'h10;
  localparam [5:0] M_END  = 6'h20;

  function rx_enabled;
    input [15:0] st;
    begin
      rx_enabled = st[`TAP_TLR] | st[`TAP_RTI] | st[`TAP_PDR] | st[`TAP_PIR];
    end
  endfunction

  function [1:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `REG_CTRL:   reg_sel = 2'h1;
        `REG_STATUS: reg_sel = 2'h2;
        `REG_RXDATA: reg_sel = 2'h3;
        default:     reg_sel = 2'h0;
      endcase
    end
  endfunction

  // Two-stage pin synchronisers
  reg        ck_m, ck_s, ck_d;
  reg        di_m, di_s;
  reg        ms_m, ms_s;
  reg        rs_m, rs_s;
  reg [9:0]  ga_m, ga_s;
  reg [2:0]  po_m, po_s;
  reg [2:0]  by_m, by_s;

  always @(posedge aclk)
  begin
    ck_m <= primary_test_clock;
    ck_s <= ck_m;
    ck_d <= ck_s;
    di_m <= primary_serial_in;
    di_s <= di_m;
    ms_m <= primary_mode_select;
    ms_s <= ms_m;
    rs_m <= primary_test_reset_n;
    rs_s <= rs_m;
    ga_m <= group_address_inputs;
    ga_s <= ga_m;
    po_m <= chain_position_inputs;
    po_s <= po_m;
    by_m <= bypass_config_inputs;
    by_s <= by_m;
  end

  wire        tck_rise = ck_s & ~ck_d;
  wire        tck_fall = ~ck_s & ck_d;
  wire [15:0] tap_state;
  wire        ack_out, ack_oe, ack_busy, ack_done;

  tap_monitor u_tap (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .force_tlr   (~rs_s),
    .step        (tck_rise),
    .mode_select (ms_s),
    .state_q     (tap_state)
  );

  // Receiver state
  reg [5:0]  msg_q;
  reg        half_q, first_q, run_q;
  reg        data_seen_q, addr_seen_q;
  reg [3:0]  acnt_q;
  reg        ones_q, zeros_q;
  reg [9:0]  addr_q;
  reg [2:0]  ccnt_q;
  reg [5:0]  cgrp_q;
  reg        cany_q, pos_hit_q;
  reg [2:0]  pos_q, cfg_q;
  reg [15:0] tap_prev_q;
  reg        eval_q, ack_start_q, bypass_q;
  reg [2:0]  result_q;
  reg [1:0]  conn_q;
  reg [2:0]  cfg_live_q;

  wire       enabled  = rx_enabled(tap_state);
  wire       pausing  = tap_state[`TAP_PDR] | tap_state[`TAP_PIR];
  wire       tap_chg  = (tap_state != tap_prev_q);
  wire       in_msg   = ~(msg_q[0] | msg_q[1]);
  wire       sym_v    = tck_rise & enabled & half_q;
  wire [1:0] sym      = {first_q, di_s};
  wire       s_idle   = (sym == `SYM_IDLE);
  wire       s_sel    = (sym == `SYM_SELECT);
  wire       s_data   = (sym == `SYM_ONE) | (sym == `SYM_ZERO);
  wire       d_bit    = (sym == `SYM_ONE);
  wire [5:0] grp_next = {d_bit, cgrp_q[5:1]};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      msg_q <= M_WAIT;
      half_q <= 1'b0;
      first_q <= 1'b1;
      run_q <= 1'b0;
      data_seen_q <= 1'b0;
      addr_seen_q <= 1'b0;
      acnt_q <= 4'h0;
      ones_q <= 1'b1;
      zeros_q <= 1'b1;
      addr_q <= 10'h000;
      ccnt_q <= 3'h0;
      cgrp_q <= 6'h00;
      cany_q <= 1'b0;
      pos_hit_q <= 1'b0;
      pos_q <= 3'h0;
      cfg_q <= 3'h0;
      tap_prev_q <= 16'h0001;
      eval_q <= 1'b0;
      ack_start_q <= 1'b0;
      result_q <= `RES_NONE;
      conn_q <= `CONN_OFF;
      cfg_live_q <= 3'h0;
    end
    else
    begin
      tap_prev_q <= tap_state;
      eval_q <= 1'b0;
      ack_start_q <= 1'b0;
      if (tap_chg && in_msg)
      begin
        msg_q <= M_WAIT;
        half_q <= 1'b0;
        run_q <= 1'b0;
        if (addr_seen_q)
        begin
          result_q <= `RES_HARD;
          conn_q <= `CONN_OFF;
        end
      end
      else if (!enabled)
      begin
        msg_q <= M_WAIT;
        half_q <= 1'b0;
        run_q <= 1'b0;
      end
      else if (tck_rise && !half_q)
      begin
        // Pair alignment is taken from the first low bit after idle
        if (msg_q == M_WAIT)
        begin
          run_q <= di_s;
          if (di_s && run_q)
            msg_q <= M_IDLE;
        end
        else if (msg_q != M_IDLE || !di_s)
        begin
          first_q <= di_s;
          half_q <= 1'b1;
        end
      end
      else if (sym_v)
      begin
        half_q <= 1'b0;
        case (msg_q)
          M_IDLE:
          begin
            if (s_sel)
            begin
              msg_q <= M_ADDR;
              data_seen_q <= 1'b0;
              addr_seen_q <= 1'b0;
              acnt_q <= 4'h0;
              ones_q <= 1'b1;
              zeros_q <= 1'b1;
              ccnt_q <= 3'h0;
              cany_q <= 1'b0;
              pos_hit_q <= 1'b0;
            end
            else if (!s_idle)
            begin
              result_q <= `RES_SOFT;
              msg_q <= M_WAIT;
              run_q <= 1'b0;
            end
          end
          M_ADDR:
          begin
            if (s_data)
            begin
              addr_q <= {d_bit, addr_q[9:1]};
              if (acnt_q != `ADDR_LONG)
                acnt_q <= acnt_q + 4'h1;
              ones_q <= ones_q & d_bit;
              zeros_q <= zeros_q & ~d_bit;
              data_seen_q <= 1'b1;
              addr_seen_q <= 1'b1;
            end
            else if (s_sel)
            begin
              if (acnt_q != 4'h0)
                msg_q <= M_MID;
            end
            else
            begin
              result_q <= data_seen_q ? `RES_HARD : `RES_SOFT;
              if (data_seen_q)
                conn_q <= `CONN_OFF;
              msg_q <= M_IDLE;
            end
          end
          M_MID, M_CMD, M_END:
          begin
            if (msg_q == M_MID && s_sel)
              msg_q <= M_CMD;
            else if (msg_q == M_CMD && s_data)
            begin
              cany_q <= 1'b1;
              cgrp_q <= grp_next;
              ccnt_q <= (ccnt_q == `CMD_GROUP_LAST) ? 3'h0 : ccnt_q + 3'h1;
              if (ccnt_q == `CMD_GROUP_LAST && grp_next[2:0] == po_s)
              begin
                pos_q <= grp_next[2:0];
                cfg_q <= grp_next[5:3];
                pos_hit_q <= 1'b1;
              end
            end
            else if (msg_q == M_CMD && s_sel)
              msg_q <= M_END;
            else if (msg_q == M_END && s_idle)
            begin
              result_q <= `RES_NO_MATCH;
              conn_q <= `CONN_OFF;
              eval_q <= 1'b1;
              msg_q <= M_IDLE;
            end
            else
            begin
              result_q <= `RES_HARD;
              conn_q <= `CONN_OFF;
              msg_q <= s_idle ? M_IDLE : M_WAIT;
              run_q <= 1'b0;
            end
          end
          default: msg_q <= M_WAIT;
        endcase
      end

      // Compare one cycle after the provisional clear
      if (eval_q)
      begin
        if (acnt_q < `ADDR_BITS)
          result_q <= `RES_HARD;
        else if (acnt_q == `ADDR_LONG)
        begin
          if (ones_q && pausing)
            result_q <= `RES_TSYNC;
          else if (zeros_q)
          begin
            result_q <= `RES_RESET;
            conn_q <= `CONN_RESET;
          end
          else
            result_q <= `RES_HARD;
        end
        else if (ccnt_q != 3'h0 || !cany_q)
          result_q <= `RES_HARD;
        else if (addr_q == ga_s && pos_hit_q)
        begin
          result_q <= `RES_MATCH;
          ack_start_q <= 1'b1;
        end
        // Else no-match stands
      end
      if (ack_done)
      begin
        conn_q <= `CONN_ON;
        cfg_live_q <= cfg_q;
      end
    end
  end

  ack_transmitter u_ack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (ack_start_q),
    .value   ({cfg_q, pos_q, addr_q}),
    .shift   (tck_fall),
    .abort   (~enabled),
    .serial_q(ack_out),
    .oe_q    (ack_oe),
    .busy_q  (ack_busy),
    .done_q  (ack_done)
  );

  // Every port leaves a flip-flop
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_serial_out <= 1'b1;
      primary_serial_out_oe <= 1'b0;
      connect_status_outputs <= `CONN_OFF;
      secondary_config <= 3'h0;
      protocol_result <= `RES_NONE;
    end
    else
    begin
      primary_serial_out <= ack_out;
      primary_serial_out_oe <= ack_oe;
      connect_status_outputs <= bypass_q ? `CONN_BYPASS : conn_q;
      secondary_config <= bypass_q ? by_s : cfg_live_q;
      protocol_result <= result_q;
    end
  end

  // AXI4-Lite slave, one access per channel
  reg        aw_full_q, w_full_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bypass_q <= `CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_full_q && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_full_q && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (aw_full_q && w_full_q && !s_axi_bvalid)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_sel(awaddr_q) == 2'h0) ? `RESP_DECERR : `RESP_OKAY;
        if (reg_sel(awaddr_q) == 2'h1 && wstrb_q[0])
          bypass_q <= wdata_q[0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        2'h1: s_axi_rdata <= {31'h00000000, bypass_q};
        2'h2: s_axi_rdata <= {tap_state, 6'h00, in_msg, ack_busy, 2'h0, conn_q, 1'b0, result_q};
        2'h3: s_axi_rdata <= {9'h000, cfg_q, 1'b0, pos_q, 6'h00, addr_q};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule
`default_nettype wire

/* verilog/tap_monitor.v */
// Sixteen-state follower of the primary TAP controller
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"

module tap_monitor (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Sampled primary TAP
  input  wire        force_tlr,
  input  wire        step,
  input  wire        mode_select,
  // Monitored state, one-hot
  output reg  [15:0] state_q
);

  localparam [15:0] TLR = 16'h0001 << `TAP_TLR;
  localparam [15:0] RTI = 16'h0001 << `TAP_RTI;
  localparam [15:0] SDR = 16'h0001 << `TAP_SDR;
  localparam [15:0] CDR = 16'h0001 << `TAP_CDR;
  localparam [15:0] SHD = 16'h0001 << `TAP_SHD;
  localparam [15:0] E1D = 16'h0001 << `TAP_E1D;
  localparam [15:0] PDR = 16'h0001 << `TAP_PDR;
  localparam [15:0] E2D = 16'h0001 << `TAP_E2D;
  localparam [15:0] UDR = 16'h0001 << `TAP_UDR;
  localparam [15:0] SIR = 16'h0001 << `TAP_SIR;
  localparam [15:0] CIR = 16'h0001 << `TAP_CIR;
  localparam [15:0] SHI = 16'h0001 << `TAP_SHI;
  localparam [15:0] E1I = 16'h0001 << `TAP_E1I;
  localparam [15:0] PIR = 16'h0001 << `TAP_PIR;
  localparam [15:0] E2I = 16'h0001 << `TAP_E2I;
  localparam [15:0] UIR = 16'h0001 << `TAP_UIR;

  reg [15:0] state_d;

  always @*
  begin
    case (state_q)
      TLR:     state_d = mode_select ? TLR : RTI;
      RTI:     state_d = mode_select ? SDR : RTI;
      SDR:     state_d = mode_select ? SIR : CDR;
      CDR:     state_d = mode_select ? E1D : SHD;
      SHD:     state_d = mode_select ? E1D : SHD;
      E1D:     state_d = mode_select ? UDR : PDR;
      PDR:     state_d = mode_select ? E2D : PDR;
      E2D:     state_d = mode_select ? UDR : SHD;
      UDR:     state_d = mode_select ? SDR : RTI;
      SIR:     state_d = mode_select ? TLR : CIR;
      CIR:     state_d = mode_select ? E1I : SHI;
      SHI:     state_d = mode_select ? E1I : SHI;
      E1I:     state_d = mode_select ? UIR : PIR;
      PIR:     state_d = mode_select ? E2I : PIR;
      E2I:     state_d = mode_select ? UIR : SHI;
      UIR:     state_d = mode_select ? SDR : RTI;
      default: state_d = TLR;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn || force_tlr)
      state_q <= TLR;
    else if (step)
      state_q <= state_d;
  end

endmodule
`default_nettype wire
